// file: hdl/ssw_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Active-low reset output stays low while undervoltage is indicated.
// - Dual-output variants drive active-high reset as exact complement.
// - Manual input low for 1 us or more guarantees a reset.
// - Undriven manual input reads high, so no reset.
// - Strobe stuck low or high for a whole watchdog period causes reset.
// - Any strobe edge or any reset clears the watchdog timer.
// - Reset held for the reset timeout after supply recovers.
// - Watchdog timeout fixed near 1.6 s, within 1.12 to 2.40 s.
// - Watchdog expiry issues a full reset pulse.
// - Build-time variants: wdog+manual low only, wdog dual, manual dual.
// - Strobe pulses of 50 ns are recognised as transitions.
// - Watchdog held at zero during reset, counts after release.
// - Floating strobe disables watchdog expiry reset.
// - Reset held for full timeout after manual input returns high.
module ssw_supervisor
   import ssw_pkg::*;
#(
   parameter ssw_variant_t VARIANT = SSW_WDOG_MANUAL_LOW,
   parameter int unsigned RESET_CYCLES = RESET_TIMEOUT_CYCLES,
   parameter int unsigned WDOG_CYCLES = WDOG_TIMEOUT_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Supply comparator
   input wire logic undervoltage_i,
   // Manual reset pin level
   input wire logic manual_reset_n_i,
   // Manual pin driven (low means floating, pulled high)
   input wire logic manual_reset_driven_i,
   // Watchdog strobe pin level
   input wire logic watchdog_strobe_in_i,
   // Strobe pin driven (low means floating)
   input wire logic watchdog_strobe_driven_i,
   // Active-low reset output
   output logic reset_n_o,
   // Active-high reset output
   output logic reset_o,
   // High when the active-high output exists
   output logic reset_high_valid_o
);
   // Watchdog present in two variants
   localparam bit HAS_WDOG = (VARIANT != SSW_MANUAL_DUAL);

   // Manual input present in two variants
   localparam bit HAS_MANUAL = (VARIANT != SSW_WDOG_DUAL);

   // Active-high output present in two variants
   localparam bit HAS_DUAL = (VARIANT != SSW_WDOG_MANUAL_LOW);

   typedef enum logic [1:0]
   {
      ST_RUN,
      ST_HOLD,
      ST_TIMEOUT
   } ssw_state_t;

   ssw_state_t state;
   logic [CNT_W-1:0] rst_cnt;
   logic [CNT_W-1:0] wd_cnt;
   logic strobe_s;
   logic strobe_q;
   logic strobe_en_s;
   logic manual_low;
   logic wd_expire;
   logic cause;
   logic reset_active;
   logic strobe_edge;
   logic strobe_live;
   logic wd_clear;
   logic rst_done;
   logic out_active;

   ssw_filt_if filt ();

   // Undriven pin is pulled high
   assign filt.raw_low = HAS_MANUAL && manual_reset_driven_i && !manual_reset_n_i;
   ssw_debounce #(.HOLD_CYCLES(GLITCH_CYCLES)) u_debounce
   (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .port(filt.filter)
   );
   assign manual_low = filt.filtered_low;

   // Strobe level sampled every 10 ns, so 50 ns pulses are always caught
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         strobe_s <= 1'b0;
      else
         strobe_s <= watchdog_strobe_in_i;
   end

   // Previous strobe level for edge detection
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         strobe_q <= 1'b0;
      else
         strobe_q <= strobe_s;
   end

   // Strobe pin driven, low while left floating
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         strobe_en_s <= 1'b0;
      else
         strobe_en_s <= watchdog_strobe_driven_i;
   end

   // Either transition services the watchdog
   // A false edge after reset only clears the timer, which is harmless
   assign strobe_edge = (strobe_s != strobe_q);

   // Timer only runs for a driven strobe in a watchdog variant
   assign strobe_live = HAS_WDOG && strobe_en_s;

   assign wd_expire = strobe_live && (wd_cnt >= CNT_W'(WDOG_CYCLES - 1));
   assign cause = undervoltage_i || manual_low;
   assign reset_active = (state != ST_RUN);
   assign rst_done = (rst_cnt >= CNT_W'(RESET_CYCLES - 1));

   // Any reset, cause or expiry restarts the timer from zero
   assign wd_clear = reset_active || cause || wd_expire;

   // Watchdog counter
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         wd_cnt <= '0;
      else if (wd_clear)
         wd_cnt <= '0;
      else if (strobe_edge)
         wd_cnt <= '0;
      else if (!strobe_live)
         wd_cnt <= '0;
      else
         wd_cnt <= wd_cnt + CNT_W'(1);
   end

   // Reset sequencer state
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         state <= ST_HOLD;
      else if (cause)
         state <= ST_HOLD;
      else
      begin
         unique case (state)
            ST_RUN:
            begin
               if (wd_expire)
                  state <= ST_TIMEOUT;
            end
            ST_HOLD:
            begin
               state <= ST_TIMEOUT;
            end
            ST_TIMEOUT:
            begin
               if (rst_done)
                  state <= ST_RUN;
            end
         endcase
      end
   end

   // Reset timeout counter, cleared on each clock while outside the timeout state
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         rst_cnt <= '0;
      else if (cause || state != ST_TIMEOUT)
         rst_cnt <= '0;
      else if (!rst_done)
         rst_cnt <= rst_cnt + CNT_W'(1);
   end

   // Output flop tracks the sequencer edge for edge, so pins never glitch
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
         out_active <= 1'b1;
      else if (cause)
         out_active <= 1'b1;
      else if (state == ST_RUN)
         out_active <= wd_expire;
      else if (state == ST_TIMEOUT && rst_done)
         out_active <= 1'b0;
      else
         out_active <= 1'b1;
   end

   // Active-low output
   assign reset_n_o = !out_active;

   // Active-high output only exists in dual variants
   assign reset_o = HAS_DUAL ? out_active : 1'b0;
   assign reset_high_valid_o = HAS_DUAL;
endmodule : ssw_supervisor

// file: hdl/ssw_pkg.sv
package ssw_pkg;
   // Clock period
   localparam int CLK_PERIOD_NS = 10;
   // Reset active timeout (min 140 ms, typ 200 ms, max 280 ms); target typical
   localparam int RESET_TIMEOUT_MS = 200;
   localparam int RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   // Watchdog timeout (min 1.12 s, typ 1.6 s, max 2.40 s); target typical
   localparam int WDOG_TIMEOUT_MS = 1600;
   localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_MS * 100000;
   // Manual reset: at least 1 us low guarantees reset
   localparam int MANUAL_MIN_NS = 1000;
   localparam int MANUAL_MIN_CYCLES = MANUAL_MIN_NS / CLK_PERIOD_NS;
   // Manual reset glitch rejection
   localparam int GLITCH_NS = 100;
   localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Strobe pulses as short as 50 ns
   localparam int STROBE_MIN_NS = 50;
   localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 28;
   localparam int FILT_W = 8;
   // Build variants
   typedef enum logic [1:0]
   {
      SSW_WDOG_MANUAL_LOW,
      SSW_WDOG_DUAL,
      SSW_MANUAL_DUAL
   } ssw_variant_t;
endpackage : ssw_pkg

// file: hdl/ssw_filt_if.sv
`timescale 1ns/1ps
interface ssw_filt_if;
   logic raw_low;
   logic filtered_low;
   modport owner (output raw_low, input filtered_low);
   modport filter (input raw_low, output filtered_low);
endinterface : ssw_filt_if

// file: hdl/ssw_debounce.sv
`timescale 1ns/1ps
module ssw_debounce
   import ssw_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = GLITCH_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Filter path
   ssw_filt_if.filter port
);
   logic [FILT_W-1:0] low_cnt;
   logic sync_a;
   logic sync_b;

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end
      else
      begin
         sync_a <= port.raw_low;
         sync_b <= sync_a;
      end
   end

   // Asserts only after the low level has persisted past the glitch window
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         low_cnt <= '0;
         port.filtered_low <= 1'b0;
      end
      else if (!sync_b)
      begin
         low_cnt <= '0;
         port.filtered_low <= 1'b0;
      end
      else if (low_cnt >= FILT_W'(HOLD_CYCLES))
         port.filtered_low <= 1'b1;
      else
         low_cnt <= low_cnt + FILT_W'(1);
   end
endmodule : ssw_debounce

// file: tb/ssw_chk.sv
`timescale 1ns/1ps
module ssw_chk
   import ssw_pkg::*;
#(
   parameter ssw_variant_t VARIANT = SSW_WDOG_MANUAL_LOW,
   parameter int unsigned RESET_CYCLES = 50,
   parameter int unsigned WDOG_CYCLES = 400
)
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic undervoltage_i,
   input wire logic manual_reset_n_i,
   input wire logic manual_reset_driven_i,
   input wire logic watchdog_strobe_in_i,
   input wire logic watchdog_strobe_driven_i,
   input wire logic reset_n_o,
   input wire logic reset_o,
   input wire logic reset_high_valid_o
);
   logic [7:0] man_cnt;
   logic [15:0] low_cnt;
   logic [15:0] st_cnt;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence uv_end; undervoltage_i ##1 !undervoltage_i; endsequence
   always_ff @(posedge ref_clk_i or posedge reset_i)
      if (reset_i)
      begin
         man_cnt <= 8'h00;
         low_cnt <= 16'h0000;
         st_cnt <= 16'h0000;
      end
      else
      begin
         man_cnt <= (manual_reset_driven_i && !manual_reset_n_i) ? man_cnt + {7'h00, man_cnt != 8'hFF} : 8'h00;
         low_cnt <= reset_n_o ? 16'h0000 : low_cnt + 16'h0001;
         st_cnt <= (reset_n_o && watchdog_strobe_driven_i && $stable(watchdog_strobe_in_i)) ? st_cnt + 16'h0001 : 16'h0000;
      end
   a_uv_forces_reset: assert property (undervoltage_i |=> !reset_n_o) else $error("undervoltage");
   a_high_output: assert property (reset_o == (reset_high_valid_o && !reset_n_o)) else $error("high out");
   a_variant_fixed: assert property ($stable(reset_high_valid_o)) else $error("variant flag");
   a_manual_asserts: assert property (VARIANT != SSW_WDOG_DUAL && man_cnt == 8'h10 |-> !reset_n_o) else $error("manual");
   a_release_hold: assert property ($rose(reset_n_o) |-> low_cnt >= RESET_CYCLES) else $error("short");
   a_uv_tail: assert property (uv_end |-> !reset_n_o [*8]) else $error("supply tail");
   a_wdog_bound: assert property (VARIANT != SSW_MANUAL_DUAL |-> st_cnt <= WDOG_CYCLES + 6) else $error("no expiry");
   a_float_quiet: assert property (!watchdog_strobe_driven_i && man_cnt == 8'h00 && !undervoltage_i && reset_n_o
      |=> reset_n_o) else $error("floating strobe");
endmodule : ssw_chk
bind ssw_supervisor ssw_chk #(.VARIANT(VARIANT), .RESET_CYCLES(RESET_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) ssw_chk_i (.ref_clk_i,
   .reset_i, .undervoltage_i, .manual_reset_n_i, .manual_reset_driven_i, .watchdog_strobe_in_i,
   .watchdog_strobe_driven_i, .reset_n_o, .reset_o, .reset_high_valid_o);

// file: tb/ssw_cpu_model.sv
`timescale 1ns/1ps
module ssw_cpu_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic float_i,
   output logic stb_o = 1'b0,
   output logic drv_o = 1'b1
);
   int cnt = 0;
   always @(posedge clk_i)
   begin
      drv_o <= !float_i;
      cnt <= cnt + 1;
      if (float_i)
         stb_o <= stb_o; // Released pin keeps its last level
      else if (!rst_n_i || (run_i && cnt % 100 == 0))
         stb_o <= rst_n_i && !stb_o;
   end
endmodule : ssw_cpu_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("ERROR %0t %h %h", $time, a, b); end end
module tb_top;
   import ssw_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic uv = 1'b0;
   logic mr_n = 1'b1;
   logic mr_drv = 1'b1;
   logic run = 1'b1;
   logic flt = 1'b0;
   logic stb, drv, rn, rh, hv;
   logic rn2, rh2, hv2;
   int fails = 0;
   int checked = 0;
   int n;
   always #5 clk = !clk;
   ssw_supervisor #(.RESET_CYCLES(50), .WDOG_CYCLES(400)) ssw_supervisor_i (.ref_clk_i(clk), .reset_i(rst),
      .undervoltage_i(uv), .manual_reset_n_i(mr_n), .manual_reset_driven_i(mr_drv), .watchdog_strobe_in_i(stb),
      .watchdog_strobe_driven_i(drv), .reset_n_o(rn), .reset_o(rh), .reset_high_valid_o(hv));
   ssw_supervisor #(.VARIANT(SSW_MANUAL_DUAL), .RESET_CYCLES(50), .WDOG_CYCLES(400)) ssw_supervisor_dual_i (
      .ref_clk_i(clk), .reset_i(rst), .undervoltage_i(uv), .manual_reset_n_i(mr_n), .manual_reset_driven_i(mr_drv),
      .watchdog_strobe_in_i(stb), .watchdog_strobe_driven_i(drv), .reset_n_o(rn2), .reset_o(rh2),
      .reset_high_valid_o(hv2));
   ssw_cpu_model ssw_cpu_model_i (.clk_i(clk), .rst_n_i(rn), .run_i(run), .float_i(flt), .stb_o(stb), .drv_o(drv));
   task automatic final_report;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic wait_rn(input logic v);
      for (n = 0; rn !== v; n++)
      begin
         @(negedge clk);
         if (n > 2000)
         begin
            fails++;
            final_report;
         end
      end
      fails += (rn !== v);
   endtask : wait_rn
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_rn(1'b1);
      `CHK(n >= 50, 1'b1)
      `CHK({rh, hv}, 2'b00)
      `CHK({rn2, rh2, hv2}, 3'b101)
      @(posedge clk);
      uv <= 1'b1;
      repeat (20) @(negedge clk);
      `CHK(rn, 1'b0)
      @(posedge clk);
      uv <= 1'b0;
      wait_rn(1'b1);
      `CHK(n >= 49, 1'b1)
      $display("supply test done");
      @(posedge clk);
      mr_n <= 1'b0;
      repeat (8) @(posedge clk);
      mr_n <= 1'b1;
      repeat (30) @(negedge clk);
      `CHK(rn, 1'b1)
      @(posedge clk);
      mr_drv <= 1'b0;
      mr_n <= 1'b0;
      repeat (200) @(negedge clk);
      `CHK(rn, 1'b1)
      @(posedge clk);
      mr_drv <= 1'b1;
      repeat (100) @(negedge clk);
      `CHK(rn, 1'b0)
      `CHK({rn2, rh2}, 2'b01)
      @(posedge clk);
      mr_n <= 1'b1;
      wait_rn(1'b1);
      `CHK(n >= 49, 1'b1)
      $display("manual test done");
      repeat (1000) @(negedge clk);
      `CHK(rn, 1'b1)
      @(posedge clk);
      run <= 1'b0;
      wait_rn(1'b0);
      `CHK(n >= 290 && n <= 410, 1'b1)
      `CHK({rn2, rh2}, 2'b10)
      wait_rn(1'b1);
      `CHK(n >= 49, 1'b1)
      @(posedge clk);
      flt <= 1'b1;
      repeat (1000) @(negedge clk);
      `CHK(rn, 1'b1)
      $display("watchdog test done");
      final_report;
   end
endmodule : tb_top
